// File: sst_params.svh
`ifndef SST_PARAMS_SVH
`define SST_PARAMS_SVH
// Register byte offsets
`define SST_OFS_CONTROL 8'h00
`define SST_OFS_TFMODE 8'h04
`define SST_OFS_RXHOLD 8'h08
`define SST_OFS_TXHOLD 8'h0C
`define SST_OFS_RXSYNC 8'h10
`define SST_OFS_TXSYNC 8'h14
`define SST_OFS_CMP0 8'h18
`define SST_OFS_CMP1 8'h1C
`define SST_OFS_STATUS 8'h20
// Transmit frame mode fields
`define SST_WLEN_LSB 0
`define SST_IDLE_BIT 5
`define SST_HBF_BIT 7
`define SST_WPF_LSB 8
`define SST_SLEN_LSB 16
`define SST_SOS_LSB 20
`define SST_SDEN_BIT 23
`define SST_SEDGE_BIT 24
`define SST_TFMODE_MASK 32'h01FF0FBF
`define SST_TFMODE_RESET 32'h00000000
`define SST_SYNC_MASK 32'h0000FFFF
// Status bit positions
`define SST_ST_TXFREE 0
`define SST_ST_TXDRAIN 1
`define SST_ST_RXAVAIL 4
`define SST_ST_OVR 5
`define SST_ST_CP0 8
`define SST_ST_CP1 9
`define SST_ST_TX_SYNC_EVENT 10
`define SST_ST_RX_SYNC_EVENT 11
`define SST_ST_TXON 16
`define SST_ST_RXON 17
// Control bit positions
`define SST_CTL_TXON 0
`define SST_CTL_RXON 1
// Sync output select codes
`define SST_SOS_NONE 3'h0
`define SST_SOS_NEG 3'h1
`define SST_SOS_POS 3'h2
`define SST_SOS_LOW 3'h3
`define SST_SOS_HIGH 3'h4
`define SST_SOS_TOG 3'h5
// Word length limits for DMA size, then bus response codes
`define SST_BYTE_MAX 5'h07
`define SST_HALF_MAX 5'h0F
`define SST_RESP_OKAY 2'h0
`define SST_RESP_SLVERR 2'h2
`endif

// File: sst_peer.sv
`timescale 1ns/1ps
module sst_peer (
	input wire logic i_tx_go,
	input wire logic [7:0] i_tx_n,
	input wire logic i_line,
	input wire logic i_sync,
	input wire logic i_rx_go,
	input wire logic [5:0] i_rx_n,
	input wire logic [47:0] i_rx_bits,
	output logic o_tx_clk,
	output logic o_rx_clk,
	output logic o_rx_data,
	output logic o_rx_sync,
	output logic o_tx_busy,
	output logic o_rx_busy,
	output logic [63:0] o_seen,
	output logic [63:0] o_sync_seen
);
	initial begin
		o_tx_clk = 1'b1;
		o_rx_clk = 1'b0;
		o_rx_data = 1'b0;
		o_rx_sync = 1'b0;
		o_tx_busy = 1'b0;
		o_rx_busy = 1'b0;
	end
	// Clock parks high between frames
	always @(posedge i_tx_go) begin
		o_tx_busy = 1'b1;
		o_seen = '0;
		o_sync_seen = '0;
		repeat (i_tx_n) begin
			#62.5 o_tx_clk = 1'b0;
			#62.5 o_tx_clk = 1'b1;
			o_seen = {o_seen[62:0], i_line};
			o_sync_seen = {o_sync_seen[62:0], i_sync};
		end
		o_tx_busy = 1'b0;
	end
	always @(posedge i_rx_go) begin
		o_rx_busy = 1'b1;
		for (int i = 0; i < i_rx_n; i++) begin
			o_rx_sync = (i == 0);
			o_rx_data = i_rx_bits[i];
			#62.5 o_rx_clk = 1'b1;
			#62.5 o_rx_clk = 1'b0;
		end
		// Released line shows the inverse
		o_rx_sync = 1'b0;
		o_rx_data = ~o_rx_data;
		o_rx_busy = 1'b0;
	end
endmodule // sst_peer

// File: sst_pkg.sv
package sst_pkg;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_SYNC = 2'b01,
		TX_DATA = 2'b10,
		TX_WAIT = 2'b11
	} sst_tx_state_t;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_SYNC = 2'b01,
		RX_DATA = 2'b10
	} sst_rx_state_t;
	typedef enum logic [1:0] {
		DMA_BYTE = 2'b00,
		DMA_HALF = 2'b01,
		DMA_WORD = 2'b10
	} sst_dma_size_t;
	typedef struct packed {
		logic sync_edge_select;
		logic sync_data_output_enable;
		logic [2:0] sync_output_select;
		logic [3:0] sync_length;
		logic [3:0] spare_hi;
		logic [3:0] words_per_frame;
		logic high_bit_first;
		logic spare_lo;
		logic idle_line_level;
		logic [4:0] word_length;
	} sst_tfmode_t;
	typedef struct packed {
		logic awready;
		logic wready;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} sst_bus_t;
	typedef struct packed {
		sst_bus_t bus;
		logic [31:0] tfmode;
		logic [15:0] tx_sync_bits;
		logic [15:0] cmp0;
		logic [15:0] cmp1;
		logic [31:0] tx_hold;
		logic tx_hold_full;
		logic transmitter_on;
		logic receiver_on;
		logic [2:0] tk_s;
		logic [2:0] rk_s;
		logic [1:0] rd_s;
		logic [2:0] rf_s;
		logic [2:0] tf_s;
		sst_tx_state_t tx_state;
		logic [31:0] tx_shift;
		logic [4:0] tx_cnt;
		logic [3:0] tx_words;
		logic serial_out_line;
		logic td_oe;
		logic transmit_sync_line;
		logic tf_oe;
		logic tf_seen;
		sst_dma_size_t dma_size;
		sst_rx_state_t rx_state;
		logic [31:0] rx_shift;
		logic [4:0] rx_cnt;
		logic [31:0] rx_hold;
		logic [15:0] rx_sync_bits;
		logic rx_word_available;
		logic rx_overflow;
		logic cp0_hit;
		logic cp1_hit;
		logic tx_sync_event;
		logic rx_sync_event;
	} sst_state_t;
endpackage

// File: sst_properties.sv
`timescale 1ns/1ps
`include "sst_params.svh"
module sst_properties (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic i_awvalid,
	input wire logic o_awready,
	input wire logic i_wvalid,
	input wire logic o_wready,
	input wire logic [1:0] o_bresp,
	input wire logic o_bvalid,
	input wire logic i_bready,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic [31:0] o_rdata,
	input wire logic [1:0] o_rresp,
	input wire logic o_rvalid,
	input wire logic i_td_open_drain,
	input wire logic i_tx_clk,
	input wire logic o_serial_out_line,
	input wire logic o_serial_out_oe
);
	logic [1:0] up_reg;
	logic tk_reg;
	logic [3:0] fall_age_reg;
	logic [3:0] wr_age_reg;
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			up_reg <= 2'h0;
			tk_reg <= 1'b1;
			fall_age_reg <= 4'hF;
			wr_age_reg <= 4'hF;
		end else begin
			up_reg <= (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
			tk_reg <= i_tx_clk;
			fall_age_reg <= (tk_reg && !i_tx_clk) ? 4'h0 : fall_age_reg + {3'h0, fall_age_reg != 4'hF};
			wr_age_reg <= (i_wvalid && o_wready) ? 4'h0 : wr_age_reg + {3'h0, wr_age_reg != 4'hF};
		end
	end
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	property p_wr_answer;
		i_awvalid && o_awready && i_wvalid && o_wready |=> ##1 o_bvalid;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write response late");
	property p_b_hold;
		o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_rd_answer;
		i_arvalid && o_arready |=> o_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read data late");
	property p_unmapped;
		i_arvalid && o_arready && i_araddr > `SST_OFS_STATUS
			|=> o_rresp == `SST_RESP_SLVERR && o_rdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
	property p_status_rsvd;
		i_arvalid && o_arready && i_araddr == `SST_OFS_STATUS |=> (o_rdata & 32'hFFFCF0CC) == 32'h0;
	endproperty
	a_status_rsvd: assert property (p_status_rsvd) else $error("status spare bits set");
	property p_sync_rsvd;
		i_arvalid && o_arready && i_araddr inside {8'h10, 8'h14, 8'h18, 8'h1C}
			|=> o_rdata[31:16] == 16'h0;
	endproperty
	a_sync_rsvd: assert property (p_sync_rsvd) else $error("upper half not zero");
	property p_open_drain;
		up_reg == 2'h3 && i_td_open_drain && $past(i_td_open_drain)
			|-> o_serial_out_oe == o_serial_out_line;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("open drain enable wrong");
	property p_line_still;
		up_reg == 2'h3 && $changed(o_serial_out_line) |-> fall_age_reg <= 4'h8 || wr_age_reg <= 4'h4;
	endproperty
	a_line_still: assert property (p_line_still) else $error("data line moved without cause");
	c_write: cover property (o_bvalid && i_bready);
	c_unmapped: cover property (i_arvalid && o_arready && i_araddr > `SST_OFS_STATUS);
	c_line: cover property ($changed(o_serial_out_line));
endmodule // sst_properties
bind sst_serial sst_properties sst_properties_i (.i_sys_clk, .i_reset_n, .i_awvalid, .o_awready,
	.i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
	.o_rdata, .o_rresp, .o_rvalid, .i_td_open_drain, .i_tx_clk, .o_serial_out_line, .o_serial_out_oe);

// File: sst_serial.sv
// Behaviour
// - Each word carries word length plus one bits
// - DMA size: byte, half-word, word by length
// - Data line idles at chosen idle level
// - Open-drain data pin enabled only when high
// - Bit order selects low or high first
// - Each frame sends words-per-frame plus one words
// - Sync pulse lasts sync length plus one periods
// - Sync length also counts shifted sync bits
// - Sync output select picks pin waveform
// - Without sync data, idle level during sync
// - With sync data, sync bits shift during sync
// - Tx sync flag on selected sync edge
// - Holding register words are right aligned
// - Received sync bits in low sixteen bits
// - Transmit sync bits read-write, low sixteen bits
// - Two sixteen-bit compare values match sync data
// - Status register flags at fixed bit positions
// - Tx free low while written word waits
// - Overflow when unread word is overwritten
// - Status read clears compare and sync flags
// - Rx available set on load, cleared when empty
`timescale 1ns/1ps
`include "sst_params.svh"
module sst_serial (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire logic i_td_open_drain,
	input wire logic i_tx_clk,
	input wire logic i_tf_in,
	input wire logic i_rx_clk,
	input wire logic i_rx_data,
	input wire logic i_rx_sync,
	output logic o_serial_out_line,
	output logic o_serial_out_oe,
	output logic o_transmit_sync_line,
	output logic o_transmit_sync_oe,
	output logic [1:0] o_tx_dma_size
);

	sst_pkg::sst_state_t state_reg;
	sst_pkg::sst_state_t state_next;

	// Bit position for counter value; used by both shifters
	function automatic logic [4:0] bit_pos(input logic [4:0] cnt, input logic [4:0] last,
			input logic hbf);
		bit_pos = hbf ? 5'(last - cnt) : cnt;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		merge = res;
	endfunction

	function automatic logic addr_ok(input logic [7:0] a, input logic wr);
		unique case (a)
			`SST_OFS_CONTROL, `SST_OFS_TFMODE, `SST_OFS_TXSYNC, `SST_OFS_CMP0,
			`SST_OFS_CMP1: addr_ok = 1'b1;
			`SST_OFS_TXHOLD: addr_ok = wr;
			`SST_OFS_RXHOLD, `SST_OFS_RXSYNC, `SST_OFS_STATUS: addr_ok = !wr;
			default: addr_ok = 1'b0;
		endcase
	endfunction

	sst_pkg::sst_tfmode_t mode;
	logic tk_rise;
	logic tk_fall;
	logic rk_rise;
	logic rf_rise;
	logic tf_level;
	logic tf_prev;
	logic sync_bit;
	logic frame_start;
	logic do_write;
	logic do_read;
	logic [31:0] status;
	logic [4:0] pos;
	logic [3:0] spos;

	always_comb begin
		state_next = state_reg;
		mode = sst_pkg::sst_tfmode_t'(state_reg.tfmode[24:0]);
		// Stage 0 of each synchroniser feeds only stage 1
		state_next.tk_s = {state_reg.tk_s[1:0], i_tx_clk};
		state_next.rk_s = {state_reg.rk_s[1:0], i_rx_clk};
		state_next.rd_s = {state_reg.rd_s[0], i_rx_data};
		state_next.rf_s = {state_reg.rf_s[1:0], i_rx_sync};
		state_next.tf_s = {state_reg.tf_s[1:0], i_tf_in};
		tk_rise = state_reg.tk_s[1] && !state_reg.tk_s[2];
		tk_fall = !state_reg.tk_s[1] && state_reg.tk_s[2];
		rk_rise = state_reg.rk_s[1] && !state_reg.rk_s[2];
		rf_rise = state_reg.rf_s[1] && !state_reg.rf_s[2];
		pos = 5'h00;
		spos = 4'h0;
		sync_bit = 1'b0;
		frame_start = 1'b0;

		status = 32'h00000000;
		status[`SST_ST_TXFREE] = !state_reg.tx_hold_full;
		status[`SST_ST_TXDRAIN] = !state_reg.tx_hold_full
			&& state_reg.tx_state == sst_pkg::TX_IDLE;
		status[`SST_ST_RXAVAIL] = state_reg.rx_word_available;
		status[`SST_ST_OVR] = state_reg.rx_overflow;
		status[`SST_ST_CP0] = state_reg.cp0_hit;
		status[`SST_ST_CP1] = state_reg.cp1_hit;
		status[`SST_ST_TX_SYNC_EVENT] = state_reg.tx_sync_event;
		status[`SST_ST_RX_SYNC_EVENT] = state_reg.rx_sync_event;
		status[`SST_ST_TXON] = state_reg.transmitter_on;
		status[`SST_ST_RXON] = state_reg.receiver_on;

		// Bus: address and data may arrive in either order
		if (i_awvalid && state_reg.bus.awready) begin
			state_next.bus.aw_got = 1'b1;
			state_next.bus.awaddr = i_awaddr;
		end
		if (i_wvalid && state_reg.bus.wready) begin
			state_next.bus.w_got = 1'b1;
			state_next.bus.wdata = i_wdata;
			state_next.bus.wstrb = i_wstrb;
		end
		if (state_reg.bus.bvalid && i_bready) begin
			state_next.bus.bvalid = 1'b0;
		end
		do_write = state_reg.bus.aw_got && state_reg.bus.w_got && !state_reg.bus.bvalid;
		if (do_write) begin
			state_next.bus.aw_got = 1'b0;
			state_next.bus.w_got = 1'b0;
			state_next.bus.bvalid = 1'b1;
			state_next.bus.bresp = addr_ok(state_reg.bus.awaddr, 1'b1)
				? `SST_RESP_OKAY : `SST_RESP_SLVERR;
			unique case (state_reg.bus.awaddr)
				`SST_OFS_CONTROL: begin
					state_next.transmitter_on = state_reg.bus.wstrb[0]
						? state_reg.bus.wdata[`SST_CTL_TXON] : state_reg.transmitter_on;
					state_next.receiver_on = state_reg.bus.wstrb[0]
						? state_reg.bus.wdata[`SST_CTL_RXON] : state_reg.receiver_on;
				end
				`SST_OFS_TFMODE: state_next.tfmode = merge(state_reg.tfmode,
					state_reg.bus.wdata, state_reg.bus.wstrb) & `SST_TFMODE_MASK;
				`SST_OFS_TXHOLD: begin
					// Right aligned word; a write over a waiting word replaces it
					state_next.tx_hold = merge(state_reg.tx_hold, state_reg.bus.wdata,
						state_reg.bus.wstrb);
					state_next.tx_hold_full = 1'b1;
				end
				`SST_OFS_TXSYNC: state_next.tx_sync_bits = 16'(merge({16'h0000,
					state_reg.tx_sync_bits}, state_reg.bus.wdata, state_reg.bus.wstrb));
				`SST_OFS_CMP0: state_next.cmp0 = 16'(merge({16'h0000, state_reg.cmp0},
					state_reg.bus.wdata, state_reg.bus.wstrb));
				`SST_OFS_CMP1: state_next.cmp1 = 16'(merge({16'h0000, state_reg.cmp1},
					state_reg.bus.wdata, state_reg.bus.wstrb));
				default: begin
				end
			endcase
		end

		if (state_reg.bus.rvalid && i_rready) begin
			state_next.bus.rvalid = 1'b0;
		end
		do_read = i_arvalid && state_reg.bus.arready;
		if (do_read) begin
			state_next.bus.rvalid = 1'b1;
			state_next.bus.rresp = addr_ok(i_araddr, 1'b0) ? `SST_RESP_OKAY : `SST_RESP_SLVERR;
			unique case (i_araddr)
				`SST_OFS_CONTROL: state_next.bus.rdata = {30'h00000000,
					state_reg.receiver_on, state_reg.transmitter_on};
				`SST_OFS_TFMODE: state_next.bus.rdata = state_reg.tfmode;
				`SST_OFS_RXHOLD: begin
					state_next.bus.rdata = state_reg.rx_hold;
					state_next.rx_word_available = 1'b0;
				end
				`SST_OFS_RXSYNC: state_next.bus.rdata = {16'h0000, state_reg.rx_sync_bits};
				`SST_OFS_TXSYNC: state_next.bus.rdata = {16'h0000, state_reg.tx_sync_bits};
				`SST_OFS_CMP0: state_next.bus.rdata = {16'h0000, state_reg.cmp0};
				`SST_OFS_CMP1: state_next.bus.rdata = {16'h0000, state_reg.cmp1};
				`SST_OFS_STATUS: begin
					state_next.bus.rdata = status;
					// Event flags clear on read; a same-cycle event sets them again below
					state_next.rx_overflow = 1'b0;
					state_next.cp0_hit = 1'b0;
					state_next.cp1_hit = 1'b0;
					state_next.tx_sync_event = 1'b0;
					state_next.rx_sync_event = 1'b0;
				end
				default: state_next.bus.rdata = 32'h00000000;
			endcase
		end

		// Transmitter shifts on falling edges of the link clock
		if (tk_fall) begin
			unique case (state_reg.tx_state)
				sst_pkg::TX_IDLE: begin
					if (state_reg.transmitter_on && state_reg.tx_hold_full) begin
						frame_start = 1'b1;
						state_next.tx_shift = state_reg.tx_hold;
						state_next.tx_hold_full = 1'b0;
						state_next.tx_words = mode.words_per_frame;
						state_next.tx_cnt = 5'h00;
						if (mode.sync_output_select == `SST_SOS_NEG
								|| mode.sync_output_select == `SST_SOS_POS
								|| mode.sync_output_select == `SST_SOS_TOG
								|| mode.sync_data_output_enable) begin
							state_next.tx_state = sst_pkg::TX_SYNC;
						end else begin
							state_next.tx_state = sst_pkg::TX_DATA;
						end
					end
				end
				sst_pkg::TX_SYNC: begin
					state_next.tx_cnt = 5'(state_reg.tx_cnt + 5'h01);
					if (state_reg.tx_cnt[3:0] == mode.sync_length) begin
						state_next.tx_cnt = 5'h00;
						state_next.tx_state = sst_pkg::TX_DATA;
					end
				end
				sst_pkg::TX_DATA: begin
					state_next.tx_cnt = 5'(state_reg.tx_cnt + 5'h01);
					if (state_reg.tx_cnt == mode.word_length) begin
						state_next.tx_cnt = 5'h00;
						if (state_reg.tx_words == 4'h0) begin
							state_next.tx_state = sst_pkg::TX_IDLE;
						end else if (state_reg.tx_hold_full) begin
							state_next.tx_shift = state_reg.tx_hold;
							state_next.tx_hold_full = 1'b0;
							state_next.tx_words = 4'(state_reg.tx_words - 4'h1);
						end else begin
							state_next.tx_state = sst_pkg::TX_WAIT;
						end
					end
				end
				sst_pkg::TX_WAIT: begin
					// Frame stays open until the remaining words arrive
					if (state_reg.tx_hold_full) begin
						state_next.tx_shift = state_reg.tx_hold;
						state_next.tx_hold_full = 1'b0;
						state_next.tx_words = 4'(state_reg.tx_words - 4'h1);
						state_next.tx_state = sst_pkg::TX_DATA;
					end
				end
			endcase

			// Line levels for the state just entered
			spos = mode.high_bit_first ? 4'(mode.sync_length - state_next.tx_cnt[3:0])
				: state_next.tx_cnt[3:0];
			sync_bit = mode.sync_data_output_enable ? state_reg.tx_sync_bits[spos]
				: mode.idle_line_level;
			pos = bit_pos(state_next.tx_cnt, mode.word_length, mode.high_bit_first);
			unique case (state_next.tx_state)
				sst_pkg::TX_SYNC: state_next.serial_out_line = sync_bit;
				sst_pkg::TX_DATA: state_next.serial_out_line = state_next.tx_shift[pos];
				default: state_next.serial_out_line = mode.idle_line_level;
			endcase

			unique case (mode.sync_output_select)
				`SST_SOS_NEG: state_next.transmit_sync_line =
					state_next.tx_state != sst_pkg::TX_SYNC;
				`SST_SOS_POS: state_next.transmit_sync_line =
					state_next.tx_state == sst_pkg::TX_SYNC;
				`SST_SOS_LOW: state_next.transmit_sync_line =
					state_next.tx_state == sst_pkg::TX_IDLE;
				`SST_SOS_HIGH: state_next.transmit_sync_line =
					state_next.tx_state != sst_pkg::TX_IDLE;
				`SST_SOS_TOG: state_next.transmit_sync_line =
					state_reg.transmit_sync_line ^ frame_start;
				default: state_next.transmit_sync_line = 1'b0;
			endcase
		end
		if (do_write && state_reg.bus.awaddr == `SST_OFS_TXHOLD) begin
			state_next.tx_hold_full = 1'b1;
		end
		if (state_reg.tx_state == sst_pkg::TX_IDLE && !tk_fall) begin
			state_next.serial_out_line = mode.idle_line_level;
		end
		state_next.tf_oe = mode.sync_output_select != `SST_SOS_NONE;
		state_next.td_oe = !i_td_open_drain || state_next.serial_out_line;

		// Sync edge watches the driven line, or the pin when it is an input
		tf_level = state_reg.tf_oe ? state_reg.transmit_sync_line : state_reg.tf_s[1];
		tf_prev = state_reg.tf_seen;
		state_next.tf_seen = tf_level;
		if (mode.sync_edge_select ? (tf_prev && !tf_level) : (!tf_prev && tf_level)) begin
			state_next.tx_sync_event = 1'b1;
		end

		if (mode.word_length <= `SST_BYTE_MAX) begin
			state_next.dma_size = sst_pkg::DMA_BYTE;
		end else if (mode.word_length <= `SST_HALF_MAX) begin
			state_next.dma_size = sst_pkg::DMA_HALF;
		end else begin
			state_next.dma_size = sst_pkg::DMA_WORD;
		end

		// Receiver samples on rising edges; a frame opens on a clock rise while sync is high
		if (rf_rise) begin
			state_next.rx_sync_event = 1'b1;
		end
		if (rk_rise) begin
			pos = bit_pos(state_reg.rx_cnt, mode.word_length, mode.high_bit_first);
			spos = mode.high_bit_first ? 4'(mode.sync_length - state_reg.rx_cnt[3:0])
				: state_reg.rx_cnt[3:0];
			unique case (state_reg.rx_state)
				sst_pkg::RX_IDLE: begin
					if (state_reg.receiver_on && state_reg.rf_s[1]) begin
						state_next.rx_state = sst_pkg::RX_SYNC;
						state_next.rx_cnt = 5'h00;
						state_next.rx_shift = 32'h00000000;
					end
				end
				sst_pkg::RX_SYNC: begin
					state_next.rx_shift[spos] = state_reg.rd_s[1];
					state_next.rx_cnt = 5'(state_reg.rx_cnt + 5'h01);
					if (state_reg.rx_cnt[3:0] == mode.sync_length) begin
						state_next.rx_sync_bits = state_next.rx_shift[15:0];
						if (state_next.rx_shift[15:0] == state_reg.cmp0) begin
							state_next.cp0_hit = 1'b1;
						end
						if (state_next.rx_shift[15:0] == state_reg.cmp1) begin
							state_next.cp1_hit = 1'b1;
						end
						state_next.rx_cnt = 5'h00;
						state_next.rx_shift = 32'h00000000;
						state_next.rx_state = sst_pkg::RX_DATA;
					end
				end
				sst_pkg::RX_DATA: begin
					state_next.rx_shift[pos] = state_reg.rd_s[1];
					state_next.rx_cnt = 5'(state_reg.rx_cnt + 5'h01);
					if (state_reg.rx_cnt == mode.word_length) begin
						state_next.rx_hold = state_next.rx_shift;
						if (state_reg.rx_word_available) begin
							state_next.rx_overflow = 1'b1;
						end
						state_next.rx_word_available = 1'b1;
						state_next.rx_state = sst_pkg::RX_IDLE;
					end
				end
				default: state_next.rx_state = sst_pkg::RX_IDLE;
			endcase
		end

		// Ready outputs are registered, so they follow the next state
		state_next.bus.awready = !state_next.bus.aw_got && !state_next.bus.bvalid;
		state_next.bus.wready = !state_next.bus.w_got && !state_next.bus.bvalid;
		state_next.bus.arready = !state_next.bus.rvalid;
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_reg <= '0;
			state_reg.tfmode <= `SST_TFMODE_RESET;
			state_reg.td_oe <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_awready = state_reg.bus.awready;
	assign o_wready = state_reg.bus.wready;
	assign o_bresp = state_reg.bus.bresp;
	assign o_bvalid = state_reg.bus.bvalid;
	assign o_arready = state_reg.bus.arready;
	assign o_rdata = state_reg.bus.rdata;
	assign o_rresp = state_reg.bus.rresp;
	assign o_rvalid = state_reg.bus.rvalid;
	assign o_serial_out_line = state_reg.serial_out_line;
	assign o_serial_out_oe = state_reg.td_oe;
	assign o_transmit_sync_line = state_reg.transmit_sync_line;
	assign o_transmit_sync_oe = state_reg.tf_oe;
	assign o_tx_dma_size = state_reg.dma_size;

endmodule // sst_serial

// File: test_sst_serial.sv
`timescale 1ns/1ps
`include "sst_params.svh"
module test_sst_serial;
	logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, od, tx_go, rx_go;
	logic [7:0] awaddr, araddr, tx_n;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp, dma;
	logic awready, wready, bvalid, arready, rvalid, line, oe, sline, soe, tk, rk, rd, rs, txb, rxb;
	logic [5:0] rx_n;
	logic [47:0] rx_bits;
	logic [63:0] seen, sseen;
	logic [7:0] reg_ofs [4] = '{`SST_OFS_TFMODE, `SST_OFS_TXSYNC, `SST_OFS_CMP0, `SST_OFS_CMP1};
	logic [31:0] reg_exp [4] = '{32'h01CF0FBF, 32'hFFFF, 32'hFFFF, 32'hFFFF};
	logic [4:0] wl_tab [4] = '{5'h07, 5'h08, 5'h0F, 5'h10};
	logic [1:0] dma_tab [4] = '{sst_pkg::DMA_BYTE, sst_pkg::DMA_HALF, sst_pkg::DMA_HALF, sst_pkg::DMA_WORD};
	int mismatches, total_checks;
	sst_serial sst_serial_i (.i_sys_clk(clk), .i_reset_n(rst_n), .i_awaddr(awaddr),
		.i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF),
		.i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
		.i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
		.o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
		.i_td_open_drain(od), .i_tx_clk(tk), .i_tf_in(1'b0), .i_rx_clk(rk), .i_rx_data(rd),
		.i_rx_sync(rs), .o_serial_out_line(line), .o_serial_out_oe(oe),
		.o_transmit_sync_line(sline), .o_transmit_sync_oe(soe), .o_tx_dma_size(dma));
	sst_peer sst_peer_i (.i_tx_go(tx_go), .i_tx_n(tx_n), .i_line(line), .i_sync(sline),
		.i_rx_go(rx_go), .i_rx_n(rx_n), .i_rx_bits(rx_bits), .o_tx_clk(tk), .o_rx_clk(rk),
		.o_rx_data(rd), .o_rx_sync(rs), .o_tx_busy(txb), .o_rx_busy(rxb), .o_seen(seen),
		.o_sync_seen(sseen));
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic limit(input logic hit);
		if (hit) begin
			mismatches++;
			$display("ERROR %0t: wait timed out", $time);
			close_out();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
		int n;
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; (aw || w) && n < 99; n++) begin
			@(posedge clk);
			aw = aw & ~awready;
			w = w & ~wready;
			awvalid <= aw;
			wvalid <= w;
		end
		for (n = n; bvalid !== 1'b1 && n < 99; n++) @(posedge clk);
		limit(n >= 99);
		chk(bresp, er);
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n == 0 || (arready !== 1'b1 && n < 99); n++) @(posedge clk);
		arvalid <= 1'b0;
		for (n = n; n < 99; n++) begin
			@(posedge clk);
			if (rvalid === 1'b1) break;
		end
		limit(n >= 99);
		chk({rresp, rdata}, {er, exp});
	endtask
	task automatic run_tx(input logic [7:0] p, input logic [31:0] w2);
		int n;
		tx_n <= p;
		tx_go <= 1'b1;
		for (n = 0; sline !== 1'b1 && n < 999; n++) @(posedge clk);
		limit(n >= 999);
		wr(`SST_OFS_TXHOLD, w2);
		for (n = 0; txb !== 1'b0 && n < 999; n++) @(posedge clk);
		limit(n >= 999);
		tx_go <= 1'b0;
	endtask
	task automatic run_rx;
		int n;
		rx_go <= 1'b1;
		repeat (2) @(posedge clk);
		for (n = 0; rxb !== 1'b0 && n < 999; n++) @(posedge clk);
		limit(n >= 999);
		rx_go <= 1'b0;
		// Synchroniser margin before the word lands
		repeat (8) @(posedge clk);
	endtask
	function automatic logic [63:0] frame_bits(input logic [15:0] sb, input int ns,
		input logic sden, input logic idle, input int wl, input logic hbf,
		input logic [31:0] w0, input logic [31:0] w1, input int nw, input int tail);
		logic [63:0] v;
		logic [31:0] w;
		v = '0;
		for (int i = 0; i < ns; i++) v = {v[62:0], sden ? sb[i] : idle};
		for (int k = 0; k < nw; k++) begin
			w = (k != 0) ? w1 : w0;
			for (int i = 0; i <= wl; i++) v = {v[62:0], hbf ? w[wl - i] : w[i]};
		end
		for (int i = 0; i < tail; i++) v = {v[62:0], idle};
		return v;
	endfunction
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready, od, tx_go, rx_go} = '0;
		{awaddr, araddr, tx_n, wdata, rx_n, rx_bits} = '0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		chk_rd(`SST_OFS_TFMODE, `SST_TFMODE_RESET);
		for (int i = 0; i < 4; i++) begin
			wr(reg_ofs[i], 32'hFFCFFFFF);
			chk_rd(reg_ofs[i], reg_exp[i]);
		end
		chk_rd(`SST_OFS_RXSYNC, 32'h0);
		chk_rd(8'h40, 32'h0, `SST_RESP_SLVERR);
		wr(`SST_OFS_RXHOLD, 32'h1, `SST_RESP_SLVERR);
		for (int i = 0; i < 4; i++) begin
			wr(`SST_OFS_TFMODE, {27'h0, wl_tab[i]});
			repeat (2) @(posedge clk);
			chk(dma, dma_tab[i]);
		end
		for (int s = 0; s < 6; s++) begin
			wr(`SST_OFS_TFMODE, {9'h0, s[2:0], 20'h7});
			repeat (2) @(posedge clk);
			chk(soe, s != 0);
		end
		$display("test registers done");
		wr(`SST_OFS_CONTROL, 32'h1);
		wr(`SST_OFS_TXSYNC, 32'h000A);
		wr(`SST_OFS_TFMODE, 32'h00A30127);
		repeat (2) @(posedge clk);
		chk(line, 1'b1);
		wr(`SST_OFS_TXHOLD, 32'hA5);
		chk_rd(`SST_OFS_STATUS, 32'h10000);
		run_tx(8'd22, 32'h3C);
		chk(seen, frame_bits(16'hA, 4, 1'b1, 1'b1, 7, 1'b0, 32'hA5, 32'h3C, 2, 2));
		chk(sseen, 64'h3C0000);
		chk_rd(`SST_OFS_STATUS, 32'h10403);
		chk_rd(`SST_OFS_STATUS, 32'h10003);
		od <= 1'b1;
		wr(`SST_OFS_TFMODE, 32'h0021008F);
		wr(`SST_OFS_TXHOLD, 32'hC3A5);
		run_tx(8'd19, 32'h1234);
		chk(seen, frame_bits(16'h0, 2, 1'b0, 1'b0, 15, 1'b1, 32'hC3A5, 0, 1, 1));
		chk(sseen, 64'h60000);
		chk(oe, 1'b0);
		chk_rd(`SST_OFS_STATUS, 32'h10400);
		od <= 1'b0;
		$display("test transmit done");
		wr(`SST_OFS_CONTROL, 32'h3);
		wr(`SST_OFS_TFMODE, 32'h00030007);
		wr(`SST_OFS_CMP0, 32'h5);
		wr(`SST_OFS_CMP1, 32'h3);
		rx_bits <= {35'h0, 8'h5A, 4'h5, 1'b0};
		rx_n <= 6'd13;
		run_rx();
		chk_rd(`SST_OFS_STATUS, 32'h30910);
		chk_rd(`SST_OFS_RXHOLD, 32'h5A);
		chk_rd(`SST_OFS_RXSYNC, 32'h5);
		run_rx();
		run_rx();
		chk_rd(`SST_OFS_STATUS, 32'h30930);
		chk_rd(`SST_OFS_STATUS, 32'h30010);
		$display("test receive done");
		close_out();
	end
endmodule // test_sst_serial
